/* File: design/urx_params.svh */
// constants for the receive status and interrupt block
// assumes a 40 MHz ref_clk and a byte-addressed plain register port
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

// register byte offsets
`define URX_OFS_STATUS 8'h00
`define URX_OFS_MODE 8'h04
`define URX_OFS_RXDATA 8'h08
`define URX_OFS_IRQ_STAT 8'h0C
`define URX_OFS_IRQ_CLR 8'h10
`define URX_OFS_IRQ_EN 8'h14
`define URX_OFS_BAUD 8'h18

// status_control field positions
`define URX_B_SEL_HI 7
`define URX_B_SEL_LO 6
`define URX_B_ADDR_EN 5
`define URX_B_IDLE 4
`define URX_B_PARITY_ERROR_FLAG 3
`define URX_B_FRAMING_ERROR_FLAG 2
`define URX_B_OVERRUN_ERROR_FLAG 1
`define URX_B_AVAIL 0

// mode register field positions
`define URX_B_PDSEL_HI 2
`define URX_B_PDSEL_LO 1

// interrupt status bit positions
`define URX_I_THR 0
`define URX_I_PARITY_ERROR_FLAG 1
`define URX_I_FRAMING_ERROR_FLAG 2
`define URX_I_OVR 3

// receive buffer and thresholds
`define URX_DEPTH 8
`define URX_CNT_W 4
`define URX_WORD_W 11
`define URX_THR_HALF 4'h4
`define URX_THR_3Q 4'h6

// selector codes
`define URX_SEL_ANY 2'h0
`define URX_SEL_HALF 2'h1
`define URX_SEL_3Q 2'h2
`define URX_PD_NONE 2'h0
`define URX_PD_ODD 2'h2
`define URX_PD_NINE 2'h3

// reset values and oversampling
`define URX_BAUD_RESET 16'h0015
`define URX_OS_MID 4'h7
`define URX_OS_LAST 4'hF

`endif

/* File: design/urx_pkg.sv */
// types for the receive status and interrupt block
// no assumptions beyond a SystemVerilog compiler
package urx_pkg;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100
  } urx_rx_state_t;

endpackage

/* File: design/urx_rx_fifo.sv */
// eight-entry receive buffer holding parity/framing flags with each character
// assumes one clock, active-low reset already synchronised
`timescale 1ns/1ps
`include "urx_params.svh"

module urx_rx_fifo (
  input wire logic refClk,
  input wire logic rstN,
  input wire logic flush,
  input wire logic pushValid,
  input wire logic [`URX_WORD_W-1:0] pushData,
  output logic pushReady,
  input wire logic popReady,
  output logic popValid,
  output logic [`URX_WORD_W-1:0] popData,
  output logic [`URX_CNT_W-1:0] count
);
  logic [`URX_WORD_W-1:0] mem [`URX_DEPTH];
  logic [2:0] wrPtr_r;
  logic [2:0] rdPtr_r;
  logic [`URX_CNT_W-1:0] count_r;
  logic doPush;
  logic doPop;

  assign pushReady = (count_r != 4'(`URX_DEPTH));
  assign popValid = (count_r != '0);
  assign popData = mem[rdPtr_r];
  assign count = count_r;
  assign doPush = pushValid && pushReady;
  assign doPop = popReady && popValid;

  always_ff @(posedge refClk) begin
    if (doPush && !flush) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  always_ff @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_r <= 3'h0;
      rdPtr_r <= 3'h0;
      count_r <= 4'h0;
    end else if (flush) begin
      wrPtr_r <= 3'h0;
      rdPtr_r <= 3'h0;
      count_r <= 4'h0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 3'h1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 3'h1;
      end
      count_r <= count_r + 4'(doPush) - 4'(doPop);
    end
  end
endmodule

/* File: design/urx_status_top.sv */
// receiver, receive status register and interrupt logic of a serial port
// assumes rxd synchronous to ref_clk and a plain one-cycle register port
// Notes on behaviour
// [R1] select 00: flag while buffer non-empty
// [R2] select 01: flag at four or more
// [R3] select 10: flag at six or more
// [R4] software never writes select value 11
// [R5] address mode keeps only ninth-bit-set characters
// [R6] address mode only acts in nine-bit mode
// [R7] idle bit high unless a character arrives
// [R8] parity error bit for current character
// [R9] framing error bit for current character
// [R10] overrun bit set when buffer overflows
// [R11] overrun set by hardware, cleared by zero
// [R12] clearing overrun empties buffer and shifter
// [R13] data-available bit high while buffer non-empty
// [R14] parity select 11 means nine bits, no parity
// [R15] receive buffer holds eight characters
// [R16] error bits follow the buffer head
`timescale 1ns/1ps
`include "urx_params.svh"

module urx_status_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic rxd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  output logic rxIrqFlag,
  output logic irqOut
);
  // ==========================================
  // reset release
  logic rstMeta_r;
  logic rstN;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // ==========================================
  // control registers
  logic [1:0] thrSel_r;
  logic addrEn_r;
  logic [1:0] pdSel_r;
  logic [15:0] baudDiv_r;
  logic [3:0] irqEn_r;
  logic [3:0] irqStat_r;
  logic overrun_error_flag_r;
  logic wrStatus;
  logic oerrClear;
  logic nineBit;

  assign wrStatus = regWrStb && (regAddr == `URX_OFS_STATUS);
  // only a written zero over a set bit clears; a written one is ignored
  assign oerrClear = wrStatus && overrun_error_flag_r && !regWrData[`URX_B_OVERRUN_ERROR_FLAG]; // R11
  assign nineBit = (pdSel_r == `URX_PD_NINE); // R14

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      thrSel_r <= 2'h0;
      addrEn_r <= 1'b0;
      pdSel_r <= 2'h0;
      baudDiv_r <= `URX_BAUD_RESET;
      irqEn_r <= 4'h0;
    end else if (regWrStb) begin
      case (regAddr)
        `URX_OFS_STATUS: begin
          thrSel_r <= regWrData[`URX_B_SEL_HI:`URX_B_SEL_LO];
          addrEn_r <= regWrData[`URX_B_ADDR_EN];
        end
        `URX_OFS_MODE: pdSel_r <= regWrData[`URX_B_PDSEL_HI:`URX_B_PDSEL_LO];
        `URX_OFS_IRQ_EN: irqEn_r <= regWrData[3:0];
        `URX_OFS_BAUD: baudDiv_r <= regWrData[15:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // oversampling tick
  logic [15:0] divCnt_r;
  logic tick;
  assign tick = (divCnt_r == 16'h0000);
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      divCnt_r <= 16'h0000;
    end else if (tick) begin
      divCnt_r <= baudDiv_r;
    end else begin
      divCnt_r <= divCnt_r - 16'h0001;
    end
  end

  // ==========================================
  // receive shift register
  urx_pkg::urx_rx_state_t state_r;
  logic [3:0] samp_r;
  logic [3:0] bitIdx_r;
  logic [8:0] shift_r;
  logic parErr_r;
  logic charDone_r;
  logic [`URX_WORD_W-1:0] charWord_r;
  logic [3:0] lastBit;
  assign lastBit = nineBit ? 4'h8 : 4'h7;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= urx_pkg::RX_IDLE;
      samp_r <= 4'h0;
      bitIdx_r <= 4'h0;
      shift_r <= 9'h000;
      parErr_r <= 1'b0;
      charDone_r <= 1'b0;
      charWord_r <= '0;
    end else begin
      charDone_r <= 1'b0;
      if (oerrClear) begin
        state_r <= urx_pkg::RX_IDLE; // R12
        shift_r <= 9'h000;
      end else begin
        case (state_r)
          urx_pkg::RX_IDLE: begin
            if (!rxd) begin
              state_r <= urx_pkg::RX_START;
              samp_r <= 4'h0;
              shift_r <= 9'h000;
              parErr_r <= 1'b0;
            end
          end
          urx_pkg::RX_START: begin
            if (tick) begin
              samp_r <= samp_r + 4'h1;
              if (samp_r == `URX_OS_MID) begin
                // a start pulse shorter than half a bit is taken as noise
                state_r <= rxd ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
                samp_r <= 4'h0;
                bitIdx_r <= 4'h0;
              end
            end
          end
          urx_pkg::RX_DATA: begin
            if (tick) begin
              samp_r <= samp_r + 4'h1;
              if (samp_r == `URX_OS_LAST) begin
                shift_r[bitIdx_r] <= rxd;
                bitIdx_r <= bitIdx_r + 4'h1;
                if (bitIdx_r == lastBit) begin
                  state_r <= (pdSel_r == `URX_PD_NONE || nineBit) ? urx_pkg::RX_STOP : urx_pkg::RX_PARITY;
                end
              end
            end
          end
          urx_pkg::RX_PARITY: begin
            if (tick) begin
              samp_r <= samp_r + 4'h1;
              if (samp_r == `URX_OS_LAST) begin
                parErr_r <= (^shift_r[7:0]) ^ rxd ^ (pdSel_r == `URX_PD_ODD);
                state_r <= urx_pkg::RX_STOP;
              end
            end
          end
          urx_pkg::RX_STOP: begin
            if (tick) begin
              samp_r <= samp_r + 4'h1;
              if (samp_r == `URX_OS_LAST) begin
                charDone_r <= 1'b1;
                charWord_r <= {parErr_r, !rxd, shift_r}; // R8 R9
                state_r <= urx_pkg::RX_IDLE;
              end
            end
          end
          default: state_r <= urx_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // receive buffer
  logic keepChar;
  logic pushValid;
  logic pushReady;
  logic popReq;
  logic popValid;
  logic [`URX_WORD_W-1:0] headWord;
  logic [`URX_CNT_W-1:0] fifoCount;
  logic overrunEv;

  // non-address characters are dropped only in nine-bit address mode
  assign keepChar = !(addrEn_r && nineBit && !charWord_r[8]); // R5 R6
  assign pushValid = charDone_r && keepChar && !overrun_error_flag_r;
  assign overrunEv = pushValid && !pushReady; // R10
  assign popReq = regRdStb && (regAddr == `URX_OFS_RXDATA);

  urx_rx_fifo u_fifo ( // R15
    .refClk(ref_clk),
    .rstN(rstN),
    .flush(oerrClear), // R12
    .pushValid(pushValid),
    .pushData(charWord_r),
    .pushReady(pushReady),
    .popReady(popReq),
    .popValid(popValid),
    .popData(headWord),
    .count(fifoCount)
  );

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      overrun_error_flag_r <= 1'b0;
    end else if (overrunEv) begin
      overrun_error_flag_r <= 1'b1; // R10
    end else if (oerrClear) begin
      overrun_error_flag_r <= 1'b0; // R11
    end
  end

  // ==========================================
  // threshold flag and interrupts
  logic thrNxt;
  always_comb begin
    case (thrSel_r)
      `URX_SEL_ANY: thrNxt = (fifoCount != '0); // R1
      `URX_SEL_HALF: thrNxt = (fifoCount >= `URX_THR_HALF); // R2
      `URX_SEL_3Q: thrNxt = (fifoCount >= `URX_THR_3Q); // R3
      default: thrNxt = 1'b0; // R4
    endcase
  end

  logic [3:0] irqEv;
  logic [3:0] irqClr;
  assign irqEv = {overrunEv, pushValid && charWord_r[9], pushValid && charWord_r[10], thrNxt && !rxIrqFlag};
  assign irqClr = (regWrStb && regAddr == `URX_OFS_IRQ_CLR) ? regWrData[3:0] : 4'h0;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rxIrqFlag <= 1'b0;
      irqStat_r <= 4'h0;
      irqOut <= 1'b0;
    end else begin
      rxIrqFlag <= thrNxt;
      // a new event wins over a clear in the same cycle
      irqStat_r <= (irqStat_r & ~irqClr) | irqEv;
      irqOut <= |(irqStat_r & irqEn_r);
    end
  end

  // ==========================================
  // register read port
  logic [31:0] statusWord;
  assign statusWord = {24'h000000, thrSel_r, addrEn_r, state_r == urx_pkg::RX_IDLE, // R7
                       popValid && headWord[10], popValid && headWord[9], // R16
                       overrun_error_flag_r, popValid}; // R13

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 32'h00000000;
    end else if (regRdStb) begin
      case (regAddr)
        `URX_OFS_STATUS: regRdData <= statusWord;
        `URX_OFS_MODE: regRdData <= {29'h00000000, pdSel_r, 1'b0};
        `URX_OFS_RXDATA: regRdData <= popValid ? {23'h000000, headWord[8:0]} : 32'h00000000;
        `URX_OFS_IRQ_STAT: regRdData <= {28'h0000000, irqStat_r};
        `URX_OFS_IRQ_EN: regRdData <= {28'h0000000, irqEn_r};
        `URX_OFS_BAUD: regRdData <= {16'h0000, baudDiv_r};
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

  // ==========================================
  // checks
  property p_thr_any;
    @(posedge ref_clk) disable iff (!rstN)
    (thrSel_r == 2'h0 && fifoCount != 4'h0) |=> rxIrqFlag;
  endproperty
  a_thr_any: assert property (p_thr_any) else $error("flag missing with data in buffer"); // R1

  property p_thr_half;
    @(posedge ref_clk) disable iff (!rstN)
    (thrSel_r == 2'h1) |=> (rxIrqFlag == ($past(fifoCount) >= 4'h4));
  endproperty
  a_thr_half: assert property (p_thr_half) else $error("half-full flag wrong"); // R2

  property p_thr_3q;
    @(posedge ref_clk) disable iff (!rstN)
    (thrSel_r == 2'h2) |=> (rxIrqFlag == ($past(fifoCount) >= 4'h6));
  endproperty
  a_thr_3q: assert property (p_thr_3q) else $error("three-quarter flag wrong"); // R3

  property p_addr_drop;
    @(posedge ref_clk) disable iff (!rstN)
    (charDone_r && addrEn_r && pdSel_r == 2'h3 && !charWord_r[8] && !oerrClear) |=>
      (fifoCount == $past(fifoCount) - 4'($past(popReq && popValid)));
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("data character stored in address mode"); // R5

  property p_addr_eight;
    @(posedge ref_clk) disable iff (!rstN)
    (charDone_r && pdSel_r != 2'h3 && !overrun_error_flag_r && fifoCount < 4'h8 && !popReq && !oerrClear) |=> (fifoCount == $past(fifoCount) + 4'h1);
  endproperty
  a_addr_eight: assert property (p_addr_eight) else $error("eight-bit character not stored"); // R6

  property p_idle;
    @(posedge ref_clk) disable iff (!rstN)
    (regRdStb && regAddr == 8'h00 && state_r != urx_pkg::RX_IDLE) |=> !regRdData[4];
  endproperty
  a_idle: assert property (p_idle) else $error("idle bit high during reception"); // R7

  property p_err_head;
    @(posedge ref_clk) disable iff (!rstN)
    (regRdStb && regAddr == 8'h00 && popValid) |=> (regRdData[3:2] == $past(headWord[10:9]));
  endproperty
  a_err_head: assert property (p_err_head) else $error("error bits do not follow buffer head"); // R16

  property p_overrun;
    @(posedge ref_clk) disable iff (!rstN)
    (charDone_r && keepChar && !overrun_error_flag_r && fifoCount == 4'h8) |=> overrun_error_flag_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R10

  property p_no_sw_set;
    @(posedge ref_clk) disable iff (!rstN)
    (!overrun_error_flag_r && !overrunEv) |=> !overrun_error_flag_r;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("overrun set without overflow"); // R11

  property p_flush;
    @(posedge ref_clk) disable iff (!rstN)
    (oerrClear && !overrunEv) |=> (fifoCount == 4'h0 && state_r == urx_pkg::RX_IDLE && !overrun_error_flag_r);
  endproperty
  a_flush: assert property (p_flush) else $error("clearing overrun did not empty receiver"); // R12

  property p_avail;
    @(posedge ref_clk) disable iff (!rstN)
    (regRdStb && regAddr == 8'h00) |=> (regRdData[0] == ($past(fifoCount) != 4'h0));
  endproperty
  a_avail: assert property (p_avail) else $error("data-available bit wrong"); // R13
endmodule

/* File: verification/urx_tx_model.sv */
// serial transmitter model driving the receive line
// assumes a baud divisor of zero, so one bit lasts BIT clocks
`timescale 1ns/1ps
module urx_tx_model #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [8:0] word,
  input wire logic nine,
  input wire logic [1:0] par,
  input wire logic badPar,
  input wire logic badStop,
  output logic rxd,
  output logic busy
);
  logic [11:0] fr;
  int len;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      fr = 12'h0;
      fr[8:1] = word[7:0];
      len = 9;
      if (nine) begin
        // ninth bit replaces parity
        fr[9] = word[8];
        len = 10;
      end else if (par != 2'h0) begin
        fr[9] = (par == 2'h1 ? ^word[7:0] : ~^word[7:0]) ^ badPar;
        len = 10;
      end
      fr[len] = ~badStop;
      for (int i = 0; i <= len; i++) begin
        rxd <= fr[i];
        repeat (BIT) @(posedge clk);
      end
      rxd <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

/* File: verification/tb_urx_status_top.sv */
// self-checking bench for the receive status and interrupt block
// assumes the transmitter model on rxd and a baud divisor of zero
`timescale 1ns/1ps
`include "urx_params.svh"
module tb_urx_status_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic rxd;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic rxIrqFlag;
  logic irqOut;
  logic go = 1'b0;
  logic [8:0] word = 9'h0;
  logic nine = 1'b0;
  logic [1:0] par = 2'h0;
  logic badPar = 1'b0;
  logic badStop = 1'b0;
  logic busy;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] d;
  logic [8:0] q[$];

  urx_status_top i_urx_status_top (
    .ref_clk(ref_clk), .nrst(nrst), .rxd(rxd), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rxIrqFlag(rxIrqFlag), .irqOut(irqOut)
  );
  urx_tx_model #(.BIT(16)) i_urx_tx_model (
    .clk(ref_clk), .go(go), .word(word), .nine(nine), .par(par),
    .badPar(badPar), .badStop(badStop), .rxd(rxd), .busy(busy)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ===================================================
  // expectations
  function automatic logic thr(input logic [1:0] s, input int c);
    case (s)
      2'h0: return c >= 1;
      2'h1: return c >= 4;
      2'h2: return c >= 6;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [31:0] st(input logic [1:0] s, input logic ad, p, f, o, a);
    return {24'h0, s, ad, 1'b1, p, f, o, a};
  endfunction

  // ===================================================
  // bus and line tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
    @(posedge ref_clk);
  endtask
  task automatic start(input logic [8:0] w, input logic n, bp, bs);
    word <= w;
    nine <= n;
    badPar <= bp;
    badStop <= bs;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task automatic finish();
    #1;
    for (int i = 0; i < 400 && busy; i++) @(posedge ref_clk);
    if (busy) begin
      bad_count++;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic send(input logic [8:0] w, input logic n, bp, bs, keep);
    start(w, n, bp, bs);
    finish();
    if (keep) q.push_back(w);
  endtask
  task automatic drain();
    while (q.size() > 0) begin
      rd(`URX_OFS_RXDATA);
      chk(d, 32'(q.pop_front()));
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ===================================================
  // tests
  initial begin
    void'($urandom(32'h1A6D076B));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h0, 0, 0, 0, 0, 0));
    rd(8'h1C);
    chk(d, 32'h0);
    wr(`URX_OFS_BAUD, 32'h0);
    // divider only reloads at its next tick, so let the old count run out
    repeat (24) @(posedge ref_clk);
    wr(`URX_OFS_STATUS, 32'h2);
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h0, 0, 0, 0, 0, 0));
    // select 11 is never written
    for (int s = 0; s < 3; s++) begin
      wr(`URX_OFS_STATUS, 32'(s) << 6);
      for (int k = 1; k <= 8; k++) begin
        send(9'($urandom_range(255)), 0, 0, 0, 1);
        chk(32'(rxIrqFlag), 32'(thr(2'(s), k)));
      end
      rd(`URX_OFS_STATUS);
      chk(d, st(2'(s), 0, 0, 0, 0, 1));
      if (s < 2) begin
        drain();
        rd(`URX_OFS_STATUS);
        chk(d, st(2'(s), 0, 0, 0, 0, 0));
      end
    end
    // ninth character overflows the eight-deep buffer
    send(9'h03C, 0, 0, 0, 0);
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h2, 0, 0, 0, 1, 1));
    rd(`URX_OFS_IRQ_STAT);
    chk(d, 32'h9);
    chk(32'(irqOut), 32'h0);
    wr(`URX_OFS_IRQ_EN, 32'hF);
    repeat (2) @(posedge ref_clk);
    chk(32'(irqOut), 32'h1);
    wr(`URX_OFS_STATUS, 32'h80);
    q.delete();
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h2, 0, 0, 0, 0, 0));
    chk(32'(rxIrqFlag), 32'h0);
    wr(`URX_OFS_IRQ_CLR, 32'hF);
    rd(`URX_OFS_IRQ_STAT);
    chk(d, 32'h0);
    chk(32'(irqOut), 32'h0);
    // odd parity, then bad parity, then bad stop bit
    wr(`URX_OFS_STATUS, 32'h0);
    wr(`URX_OFS_MODE, 32'h4);
    par <= 2'h2;
    start(9'h0C3, 0, 0, 0);
    q.push_back(9'h0C3);
    repeat (60) @(posedge ref_clk);
    rd(`URX_OFS_STATUS);
    chk(d & 32'h10, 32'h0);
    finish();
    send(9'($urandom_range(255)), 0, 1, 0, 1);
    send(9'($urandom_range(255)), 0, 0, 1, 1);
    rd(`URX_OFS_IRQ_STAT);
    chk(d, 32'h7);
    chk(32'(irqOut), 32'h1);
    for (int i = 0; i < 3; i++) begin
      rd(`URX_OFS_STATUS);
      chk(d, st(2'h0, 0, i == 1, i == 2, 0, 1));
      rd(`URX_OFS_RXDATA);
      chk(d, 32'(q.pop_front()));
    end
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h0, 0, 0, 0, 0, 0));
    // even parity: a good character, then a bad one
    wr(`URX_OFS_MODE, 32'h2);
    par <= 2'h1;
    send(9'($urandom_range(255)), 0, 0, 0, 1);
    send(9'($urandom_range(255)), 0, 1, 0, 1);
    for (int i = 0; i < 2; i++) begin
      rd(`URX_OFS_STATUS);
      chk(d, st(2'h0, 0, i == 1, 0, 0, 1));
      rd(`URX_OFS_RXDATA);
      chk(d, 32'(q.pop_front()));
    end
    // nine-bit mode with and without address detect
    wr(`URX_OFS_MODE, 32'h6);
    par <= 2'h0;
    send(9'h155, 1, 0, 0, 1);
    wr(`URX_OFS_STATUS, 32'h20);
    send(9'h0AA, 1, 0, 0, 0);
    send(9'h1A5, 1, 0, 0, 1);
    drain();
    rd(`URX_OFS_STATUS);
    chk(d, st(2'h0, 1, 0, 0, 0, 0));
    wr(`URX_OFS_MODE, 32'h0);
    send(9'h055, 0, 0, 0, 1);
    drain();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule
